// ===== include/rts_pkg.sv
// Purpose: Shared constants and types of the radio top sequencer.
// Assumes: One clock, sys_clk_i at 125 MHz; synchronous reset.
// Notes: Timer durations are given to the device in clock cycles.
package rts_pkg;
  localparam int TW = 24;
  localparam int CLK_MHZ = 125;
  localparam int T1_MIN_US = 64;
  localparam logic [TW-1:0] T1_MIN_CYC = TW'(T1_MIN_US * CLK_MHZ);
  localparam logic [2:0] RXX_SYNC_OFF = 3'h5;
  localparam logic [2:0] RXX_PRE_OFF = 3'h6;
  localparam logic [1:0] START_LOWPWR = 2'h0;
  localparam logic [1:0] RXTO_LOWPWR = 2'h2;
  localparam logic [1:0] PIN_MAP_EVT = 2'h3;
  localparam logic [TW-1:0] CNT_ZERO = 24'h000000;
  typedef enum logic [2:0] {
    RTS_OFF = 3'h0,
    RTS_IDLE = 3'h1,
    RTS_RX = 3'h3,
    RTS_TX = 3'h2,
    RTS_HOLD = 3'h6
  } rts_state_e;
endpackage

// ===== include/rts_if.sv
// Purpose: Joins host end and sequencer end of the radio.
// Assumes: Both ends on sys_clk_i.
// Notes: Configuration is held as loose bits driven by the host.
`timescale 1ns/1ps
interface rts_if;
  logic seq_start;
  logic seq_halt_bit;
  logic low_power_state_select;
  logic [1:0] start_transition_select;
  logic sleep_branch_select;
  logic idle_exit_select;
  logic [2:0] rx_exit_select;
  logic [1:0] rx_expiry_exit_select;
  logic tx_exit_select;
  logic periodic_repeat_enable;
  logic preamble_pin_map_select;
  logic [1:0] pin2_map;
  logic [1:0] pin4_map;
  logic [rts_pkg::TW-1:0] first_interval_timer;
  logic [rts_pkg::TW-1:0] second_interval_timer;
  logic [rts_pkg::TW-1:0] preamble_wait_limit;
  logic seq_running;
  logic radio_rx;
  logic radio_tx;
  logic radio_sleep;
  logic event_pin2;
  logic event_pin4;
  logic tx_launch;
  modport dev (
    input seq_start, seq_halt_bit, low_power_state_select,
    input start_transition_select, sleep_branch_select, idle_exit_select,
    input rx_exit_select, rx_expiry_exit_select, tx_exit_select,
    input periodic_repeat_enable, preamble_pin_map_select,
    input pin2_map, pin4_map, first_interval_timer,
    input second_interval_timer, preamble_wait_limit,
    output seq_running, radio_rx, radio_tx, radio_sleep,
    output event_pin2, event_pin4, tx_launch
  );
  modport host (
    output seq_start, seq_halt_bit, low_power_state_select,
    output start_transition_select, sleep_branch_select, idle_exit_select,
    output rx_exit_select, rx_expiry_exit_select, tx_exit_select,
    output periodic_repeat_enable, preamble_pin_map_select,
    output pin2_map, pin4_map, first_interval_timer,
    output second_interval_timer, preamble_wait_limit,
    input seq_running, radio_rx, radio_tx, radio_sleep,
    input event_pin2, event_pin4, tx_launch
  );
endinterface

// ===== src/rts_seq_dev.sv
// Purpose: Top sequencer stepping sleep, receive and transmit.
// Assumes: Radio events are one-cycle pulses synchronous to sys_clk_i.
// Notes: Timer values are cycle counts; zero is treated as one cycle.
//        Second_interval_timer runs from each idle exit and first_interval_timer only after it, so a
//        transmit shorter than the period does not stretch it.
`timescale 1ns/1ps
module rts_seq_dev (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  rts_if.dev bus,
  input wire logic preamble_found_event_i,
  input wire logic sync_word_match_event_i,
  input wire logic tx_done_event_i,
  input wire logic frame_ready_i,
  output logic beacon_blocked_o
);
  rts_pkg::rts_state_e state_reg;
  // Down-counters for the two period timers and the preamble wait
  logic [rts_pkg::TW-1:0] t1_reg;
  logic [rts_pkg::TW-1:0] t2_reg;
  logic [rts_pkg::TW-1:0] to_reg;
  logic pre_seen_reg;
  // Decoded timer and exit conditions
  logic t1_exp;
  logic t2_exp;
  logic to_exp;
  logic halt;
  logic rx_done_sync;
  logic rx_done_pre;
  logic rx_timed_out;
  logic go;

  // Timer expiry: count reaching one means the period ran out
  // Stopping at one rather than zero lets a value of zero mean one cycle
  function automatic logic expired(input logic [rts_pkg::TW-1:0] c);
    expired = (c <= rts_pkg::TW'(1));
  endfunction

  assign t1_exp = expired(t1_reg);
  assign t2_exp = expired(t2_reg);
  assign to_exp = expired(to_reg);
  assign halt = bus.seq_halt_bit;
  assign rx_done_sync = (bus.rx_exit_select == rts_pkg::RXX_SYNC_OFF)
                        && sync_word_match_event_i;
  assign rx_done_pre = (bus.rx_exit_select == rts_pkg::RXX_PRE_OFF)
                       && preamble_found_event_i;

  // Preamble wait ran out with nothing heard; an event in the last
  // cycle still counts as in time, so it is excluded here
  assign rx_timed_out = !pre_seen_reg && to_exp && !preamble_found_event_i
                        && bus.rx_expiry_exit_select == rts_pkg::RXTO_LOWPWR;

  // Idle exit: first_interval_timer ran out, which for a value above one can only happen after second_interval_timer did
  assign go = (state_reg == rts_pkg::RTS_IDLE) && t1_exp &&
              bus.sleep_branch_select && !halt;

  // Main sequencer state; halt always wins so the loop can be stopped
  // Halting from any state returns to off, ready for a fresh start
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      state_reg <= rts_pkg::RTS_OFF;
    else if (halt)
      state_reg <= rts_pkg::RTS_OFF;
    else
    begin
      unique case (state_reg)
        rts_pkg::RTS_OFF:
          if (bus.seq_start &&
              bus.start_transition_select == rts_pkg::START_LOWPWR)
            state_reg <= rts_pkg::RTS_IDLE;
        rts_pkg::RTS_IDLE:
          if (go)
            state_reg <= bus.idle_exit_select ? rts_pkg::RTS_RX
                                              : rts_pkg::RTS_TX;
        // A stop event outranks both timers, so a sync word heard on the
        // last cycle of the window still leaves the receiver on
        rts_pkg::RTS_RX:
          if (rx_done_sync || rx_done_pre)
            state_reg <= rts_pkg::RTS_HOLD;
          else if (rx_timed_out)
            state_reg <= rts_pkg::RTS_IDLE;
          else if (t2_exp)
            state_reg <= rts_pkg::RTS_IDLE;
        rts_pkg::RTS_TX:
          if (tx_done_event_i && !bus.tx_exit_select)
            state_reg <= rts_pkg::RTS_IDLE;
        // Receiver stays on with the sequencer off until the host halts
        rts_pkg::RTS_HOLD:
          state_reg <= rts_pkg::RTS_HOLD;
        default:
          state_reg <= rts_pkg::RTS_OFF;
      endcase
    end
  end

  // First timer: reloaded at each idle exit and held there until the
  // second timer has emptied, then counted down to the next exit. The
  // two add up to one period, whatever time receive took or a transmit took within the period.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      t1_reg <= rts_pkg::CNT_ZERO;
    else if (state_reg == rts_pkg::RTS_OFF || go)
      t1_reg <= bus.first_interval_timer;
    else if (t2_reg == rts_pkg::CNT_ZERO && !t1_exp)
      t1_reg <= t1_reg - rts_pkg::TW'(1);
  end

  // Second timer: loaded at each idle exit, runs to zero in any state.
  // Held empty while off so the first period starts with first_interval_timer alone.
  // It also bounds the receive window once a preamble was found.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      t2_reg <= rts_pkg::CNT_ZERO;
    else if (state_reg == rts_pkg::RTS_OFF)
      t2_reg <= rts_pkg::CNT_ZERO;
    else if (go)
      t2_reg <= bus.second_interval_timer;
    else if (t2_reg != rts_pkg::CNT_ZERO)
      t2_reg <= t2_reg - rts_pkg::TW'(1);
  end

  // Preamble wait limit, reloaded at every receive start
  // Counting stops at one so the exit test stays true until it is used
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      to_reg <= rts_pkg::CNT_ZERO;
    else if (state_reg != rts_pkg::RTS_RX)
      to_reg <= bus.preamble_wait_limit;
    else if (!to_exp)
      to_reg <= to_reg - rts_pkg::TW'(1);
  end

  // A preamble inside the window keeps receive until second_interval_timer ends. A
  // preamble on the window's last cycle counts too, matching the exit
  // test, or receive would drop one cycle after it stayed for it.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      pre_seen_reg <= 1'b0;
    else if (state_reg != rts_pkg::RTS_RX)
      pre_seen_reg <= 1'b0;
    else if (preamble_found_event_i)
      pre_seen_reg <= 1'b1;
  end

  // Radio mode outputs, registered: they trail the state by one cycle,
  // which keeps every output of the block straight from a flip-flop
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bus.seq_running <= 1'b0;
      bus.radio_rx <= 1'b0;
      bus.radio_tx <= 1'b0;
      bus.radio_sleep <= 1'b0;
    end
    else
    begin
      bus.seq_running <= (state_reg != rts_pkg::RTS_OFF) &&
                         (state_reg != rts_pkg::RTS_HOLD);
      bus.radio_rx <= (state_reg == rts_pkg::RTS_RX) ||
                      (state_reg == rts_pkg::RTS_HOLD);
      bus.radio_tx <= (state_reg == rts_pkg::RTS_TX);
      bus.radio_sleep <= (state_reg == rts_pkg::RTS_IDLE) &&
                         bus.low_power_state_select;
    end
  end

  // Beacon resend: fires on each transmit entry when buffer is reusable
  // A changed or oversized frame blocks the resend; the host must refill
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bus.tx_launch <= 1'b0;
      beacon_blocked_o <= 1'b0;
    end
    else
    begin
      bus.tx_launch <= bus.periodic_repeat_enable && frame_ready_i &&
                       go && !bus.idle_exit_select;
      beacon_blocked_o <= bus.periodic_repeat_enable && !frame_ready_i;
    end
  end

  // Event pin routing; pin 4 needs the extra preamble select bit
  // Pins lag their events by one cycle, like every other output
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bus.event_pin2 <= 1'b0;
      bus.event_pin4 <= 1'b0;
    end
    else
    begin
      bus.event_pin2 <= (bus.pin2_map == rts_pkg::PIN_MAP_EVT) &&
                        sync_word_match_event_i;
      bus.event_pin4 <= (bus.pin4_map == rts_pkg::PIN_MAP_EVT) &&
                        bus.preamble_pin_map_select &&
                        preamble_found_event_i;
    end
  end
endmodule // rts_seq_dev

// ===== src/rts_host_end.sv
// Purpose: Host end driving the sequencer configuration bits.
// Assumes: User side holds mode and timings as levels.
// Notes: First_interval_timer is floored at its shortest legal duration.
`timescale 1ns/1ps
module rts_host_end (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  rts_if.host bus,
  input wire logic beacon_mode_i,
  input wire logic start_i,
  input wire logic halt_i,
  input wire logic [rts_pkg::TW-1:0] period1_i,
  input wire logic [rts_pkg::TW-1:0] period2_i,
  input wire logic [rts_pkg::TW-1:0] preamble_wait_i,
  output logic sync_seen_o,
  output logic preamble_seen_o,
  output logic running_o
);
  // Configuration: listen or beacon recipe, first_interval_timer floored to 64 us
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bus.seq_start <= 1'b0;
      bus.seq_halt_bit <= 1'b0;
      bus.low_power_state_select <= 1'b1;
      bus.start_transition_select <= rts_pkg::START_LOWPWR;
      bus.sleep_branch_select <= 1'b1;
      bus.idle_exit_select <= 1'b1;
      bus.rx_exit_select <= rts_pkg::RXX_SYNC_OFF;
      bus.rx_expiry_exit_select <= rts_pkg::RXTO_LOWPWR;
      bus.tx_exit_select <= 1'b0;
      bus.periodic_repeat_enable <= 1'b0;
      bus.preamble_pin_map_select <= 1'b1;
      bus.pin2_map <= rts_pkg::PIN_MAP_EVT;
      bus.pin4_map <= rts_pkg::PIN_MAP_EVT;
      bus.first_interval_timer <= rts_pkg::T1_MIN_CYC;
      bus.second_interval_timer <= rts_pkg::T1_MIN_CYC;
      bus.preamble_wait_limit <= rts_pkg::T1_MIN_CYC;
    end
    else
    begin
      bus.seq_start <= start_i;
      bus.seq_halt_bit <= halt_i;
      bus.idle_exit_select <= !beacon_mode_i;
      bus.periodic_repeat_enable <= beacon_mode_i;
      bus.first_interval_timer <= (period1_i < rts_pkg::T1_MIN_CYC) ?
                                  rts_pkg::T1_MIN_CYC : period1_i;
      bus.second_interval_timer <= period2_i;
      bus.preamble_wait_limit <= preamble_wait_i;
    end
  end

  // Watch event pins and running status
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sync_seen_o <= 1'b0;
      preamble_seen_o <= 1'b0;
      running_o <= 1'b0;
    end
    else
    begin
      sync_seen_o <= bus.event_pin2;
      preamble_seen_o <= bus.event_pin4;
      running_o <= bus.seq_running;
    end
  end
endmodule // rts_host_end

// ===== testbench/rts_seq_assertions.sv
// Purpose: Assertions on the wires between host end and sequencer end.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: A few cycles of slack cover the state-step overhead.
`timescale 1ns/1ps
module rts_seq_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic seq_halt_bit,
  input wire logic idle_exit_select,
  input wire logic [2:0] rx_exit_select,
  input wire logic [1:0] pin2_map,
  input wire logic [1:0] pin4_map,
  input wire logic preamble_pin_map_select,
  input wire logic seq_running,
  input wire logic radio_rx,
  input wire logic radio_tx,
  input wire logic radio_sleep,
  input wire logic event_pin2,
  input wire logic event_pin4,
  input wire logic tx_launch
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Sync match seen on pin 2 while receiving with exit code 101
  sequence s_sync_hit;
    event_pin2 && radio_rx && !seq_halt_bit &&
      rx_exit_select == rts_pkg::RXX_SYNC_OFF;
  endsequence
  // Sequencer stopped but the receiver left on
  sequence s_held_rx;
    !seq_running && radio_rx;
  endsequence
  a_sync_holds_rx: assert property (s_sync_hit |-> ##[0:3] s_held_rx)
    else $error("sync match did not stop sequencer in receive");
  a_halt_stops_seq: assert property (seq_halt_bit |->
    ##[1:3] !seq_running)
    else $error("halt did not stop the sequencer");
  a_pin2_map_gate: assert property (event_pin2 |->
    $past(pin2_map) == rts_pkg::PIN_MAP_EVT)
    else $error("pin 2 pulsed without its mapping");
  a_pin4_map_gate: assert property (event_pin4 |->
    $past(preamble_pin_map_select) &&
    $past(pin4_map) == rts_pkg::PIN_MAP_EVT)
    else $error("pin 4 pulsed without its mapping");
  a_pin2_one_cycle: assert property (event_pin2 |=> !event_pin2)
    else $error("pin 2 pulse longer than one cycle");
  // Launch only in beacon recipe, and transmit follows it
  a_launch_to_tx: assert property (tx_launch |->
    !idle_exit_select ##[0:2] radio_tx)
    else $error("launch without beacon transmit");
  a_rx_tx_apart: assert property (!(radio_rx && radio_tx))
    else $error("receive and transmit together");
  a_rx_not_sleep: assert property (!(radio_rx && radio_sleep))
    else $error("receive while asleep");
  a_listen_no_tx: assert property (seq_running && idle_exit_select
    |-> !radio_tx)
    else $error("transmit in listen recipe");
endmodule // rts_seq_assertions

// ===== testbench/tb_radio_top_sequencer_listen_beacon.sv
// Purpose: Self-checking bench joining host end and sequencer end.
// Assumes: Host floors first_interval_timer to 64 us; events are one-cycle pulses.
// Notes: Pin events are counted, so pulse alignment does not matter.
`timescale 1ns/1ps
module tb_radio_top_sequencer_listen_beacon;
  localparam int P1 = rts_pkg::T1_MIN_US * rts_pkg::CLK_MHZ;
  localparam int P2 = 200;
  localparam int SL = 8; // Slack for state overhead per period
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bmode = 1'b0;
  logic start = 1'b0;
  logic halt = 1'b0;
  logic [2:0] evt = 3'h0;
  logic frame_ready = 1'b1;
  logic blocked, sync_seen, pre_seen, running;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int t0 = 0;
  int hits2 = 0;
  int hits4 = 0;
  int n_launch = 0;
  logic [1:0] seen = 2'h0;
  rts_if bus_if ();
  // First_interval_timer deliberately below its floor to expose a missing clamp
  rts_host_end i_rts_host_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus(bus_if.host), .beacon_mode_i(bmode), .start_i(start),
    .halt_i(halt), .period1_i(24'h00000A), .period2_i(24'h0000C8),
    .preamble_wait_i(24'h000032), .sync_seen_o(sync_seen),
    .preamble_seen_o(pre_seen), .running_o(running));
  rts_seq_dev i_rts_seq_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus(bus_if.dev), .preamble_found_event_i(evt[0]),
    .sync_word_match_event_i(evt[1]), .tx_done_event_i(evt[2]),
    .frame_ready_i(frame_ready), .beacon_blocked_o(blocked));
  rts_seq_assertions i_rts_seq_assertions (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .seq_halt_bit(bus_if.seq_halt_bit),
    .idle_exit_select(bus_if.idle_exit_select),
    .rx_exit_select(bus_if.rx_exit_select), .pin2_map(bus_if.pin2_map),
    .pin4_map(bus_if.pin4_map),
    .preamble_pin_map_select(bus_if.preamble_pin_map_select),
    .seq_running(bus_if.seq_running), .radio_rx(bus_if.radio_rx),
    .radio_tx(bus_if.radio_tx), .radio_sleep(bus_if.radio_sleep),
    .event_pin2(bus_if.event_pin2), .event_pin4(bus_if.event_pin4),
    .tx_launch(bus_if.tx_launch));
  // Clock and cycle count
  initial forever #4 sys_clk_i = ~sys_clk_i;
  // Pin pulses are tallied, avoiding a guess at their exact cycle
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (bus_if.event_pin2 === 1'b1) hits2 <= hits2 + 1;
    if (bus_if.event_pin4 === 1'b1) hits4 <= hits4 + 1;
    if (bus_if.tx_launch === 1'b1) n_launch <= n_launch + 1;
    if (sync_seen === 1'b1) seen[1] <= 1'b1;
    if (pre_seen === 1'b1) seen[0] <= 1'b1;
  end
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic sig(input int k);
    return (k == 0) ? bus_if.radio_rx : bus_if.radio_tx;
  endfunction
  // Bounded wait so that a stuck sequencer fails instead of hanging
  task automatic wait_lvl(input int k, input logic v, input int lim);
    int n = 0;
    while (sig(k) !== v && n < lim)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("radio level", {31'h0, v}, {31'h0, sig(k)});
  endtask
  task automatic pulse(input int k);
    @(negedge sys_clk_i);
    evt[k] = 1'b1;
    @(negedge sys_clk_i);
    evt = 3'h0;
  endtask
  // Next start must come one first_interval_timer plus second_interval_timer after the last
  task automatic period_chk(input int k);
    wait_lvl(k, 1'b0, P1 + P2);
    wait_lvl(k, 1'b1, P1 + P2 + SL);
    chk("start spacing", 32'h1,
      {31'h0, (cyc - t0 >= P1 + P2) && (cyc - t0 <= P1 + P2 + SL)});
    t0 = cyc;
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog sized some three periods above the full sequence of periods
  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    start = 1'b1;
    wait_lvl(0, 1'b1, P1 + SL);
    t0 = cyc;
    wait_lvl(0, 1'b0, 50 + SL);
    repeat (3) @(negedge sys_clk_i);
    chk("sleep", 32'h1, {31'h0, bus_if.radio_sleep});
    period_chk(0);
    pulse(0);
    repeat (100) @(negedge sys_clk_i);
    chk("pin4 hits", 32'h1, {31'h0, hits4 > 0});
    chk("rx kept", 32'h1, {31'h0, bus_if.radio_rx});
    period_chk(0);
    pulse(0);
    pulse(1);
    repeat (10) @(negedge sys_clk_i);
    chk("pin2 hits", 32'h1, {31'h0, hits2 > 0});
    chk("host seen", 32'h3, {30'h0, seen});
    chk("seq off", 32'h0, {31'h0, running});
    repeat (P1 + P2) @(negedge sys_clk_i);
    chk("rx held", 32'h1, {31'h0, bus_if.radio_rx});
    halt = 1'b1;
    start = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    bmode = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    halt = 1'b0;
    start = 1'b1;
    wait_lvl(1, 1'b1, P1 + SL);
    t0 = cyc;
    pulse(2);
    repeat (4) @(negedge sys_clk_i);
    chk("tx off", 32'h0, {31'h0, bus_if.radio_tx});
    period_chk(1);
    pulse(2);
    period_chk(1);
    frame_ready = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk("blocked", 32'h1, {31'h0, blocked});
    halt = 1'b1;
    repeat (P1 + P2 + SL) @(negedge sys_clk_i);
    chk("halt run", 32'h0, {31'h0, running});
    chk("halt tx", 32'h0, {31'h0, bus_if.radio_tx});
    chk("launches", 32'h3, n_launch);
    wrap_up();
  end
endmodule // tb_radio_top_sequencer_listen_beacon
